//--- rtl/virtual_page_relocation.sv
// Virtual to physical page relocation with Avalon-MM register access
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`include "vpr_regs.svh"

module virtual_page_relocation #(
  parameter int PAGES = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire vpr_pkg::xlat_req_t xlat_req,
  output vpr_pkg::xlat_rsp_t xlat_rsp,
  output logic priv_instr_ok,
  input wire logic sp_wr,
  input wire logic [15:0] sp_wdata,
  output logic [15:0] sp_rdata
);

  localparam int ENTRIES = 2 * PAGES;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [15:0] base_mem [ENTRIES];
  logic [15:0] desc_mem [ENTRIES];
  logic map_en_reg;
  logic map_en_next;
  logic [3:0] stat_reg;
  logic [3:0] stat_next;
  logic [3:0] ien_reg;
  logic [3:0] ien_next;
  logic resp_reg;
  logic resp_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [15:0] sp_reg [2];
  vpr_pkg::xlat_rsp_t rsp_reg;
  vpr_pkg::xlat_rsp_t rsp_next;

  // ----------------------------------------
  // Translation path
  // ----------------------------------------
  logic bank;
  logic [3:0] idx;
  logic [2:0] page;
  logic [6:0] blk;
  logic [1:0] key;
  logic [6:0] len;
  logic [11:0] base;
  logic mode_bad;
  logic key_bad;
  logic ro_bad;
  logic len_bad;
  logic abort_c;
  logic [3:0] ev;
  logic [17:0] mapped_pa;
  logic [17:0] flat_pa;

  // Entry select and checks, all from one cycle of the request
  always_comb begin
    bank = (xlat_req.mode == `VPR_MODE_UNPRIV);
    page = xlat_req.vaddr[15:13];
    idx = {bank, page};
    blk = xlat_req.vaddr[12:6];
    base = base_mem[idx][`VPR_BASE_W-1:0];
    key = desc_mem[idx][`VPR_KEY_LSB +: 2];
    len = desc_mem[idx][`VPR_LEN_LSB +: 7];
    mode_bad = (xlat_req.mode != `VPR_MODE_PRIV) && !bank;
    key_bad = (key != `VPR_KEY_RO) && (key != `VPR_KEY_RW);
    ro_bad = (key == `VPR_KEY_RO) && xlat_req.write;
    len_bad = blk > len;
    // No overlap check: aliasing entries are legal
    mapped_pa = {base, 6'h00} + {5'h00, xlat_req.vaddr[12:0]};
    flat_pa = {(page == `VPR_IO_PAGE) ? `VPR_IO_EXT : 2'h0, xlat_req.vaddr};
    ev = '0;
    // Only the first failing check is logged, mode before key before length
    if (mode_bad) begin
      ev[`VPR_EV_MODE] = 1'b1;
    end else if (key_bad) begin
      ev[`VPR_EV_KEY] = 1'b1;
    end else if (ro_bad) begin
      ev[`VPR_EV_RO] = 1'b1;
    end else if (len_bad) begin
      ev[`VPR_EV_LEN] = 1'b1;
    end
    abort_c = map_en_reg && (ev != '0);
  end

  // Answer is registered; an abort never shows done or an address
  always_comb begin
    rsp_next = '0;
    if (xlat_req.valid) begin
      if (!map_en_reg) begin
        rsp_next.done = 1'b1;
        rsp_next.paddr = flat_pa;
      end else if (abort_c) begin
        rsp_next.abort = 1'b1;
      end else begin
        rsp_next.done = 1'b1;
        rsp_next.paddr = mapped_pa;
      end
    end
    rsp_next.io_page = rsp_next.done && (rsp_next.paddr[17:13] == 5'h1f);
  end

  // Answer register; reset clears it so no stale done follows reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign xlat_rsp = rsp_reg;

  // ----------------------------------------
  // Mode side effects
  // ----------------------------------------
  // Privileged-only instructions are allowed in mode 00 alone
  assign priv_instr_ok = (xlat_req.mode == `VPR_MODE_PRIV);

  // One stack pointer per mode; illegal codes fall to the unprivileged one
  logic sp_sel;
  logic [15:0] sp_next [2];

  always_comb begin
    sp_sel = (xlat_req.mode != `VPR_MODE_PRIV);
    sp_next[0] = sp_reg[0];
    sp_next[1] = sp_reg[1];
    if (sp_wr) begin
      sp_next[sp_sel] = sp_wdata;
    end
  end

  // Stack pointer pair
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sp_reg[0] <= `VPR_SP_RST;
      sp_reg[1] <= `VPR_SP_RST;
    end else begin
      sp_reg[0] <= sp_next[0];
      sp_reg[1] <= sp_next[1];
    end
  end

  assign sp_rdata = sp_reg[sp_sel];

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  logic access;
  logic wr_go;
  logic is_entry;
  logic [3:0] widx;
  logic base_we;
  logic desc_we;
  logic [3:0] clr_mask;

  // Each access waits exactly one cycle; read data is latched then
  always_comb begin
    access = avs_read || avs_write;
    resp_next = access && !resp_reg;
    wr_go = avs_write && resp_reg;
    is_entry = avs_address < `VPR_ENTRY_TOP;
    widx = {avs_address[`VPR_BANK_BIT], avs_address[4:2]};
    base_we = wr_go && is_entry && !avs_address[`VPR_KIND_BIT];
    desc_we = wr_go && is_entry && avs_address[`VPR_KIND_BIT];
    rdata_next = rdata_reg;
    if (avs_read && !resp_reg) begin
      rdata_next = '0;
      if (is_entry) begin
        rdata_next[15:0] = avs_address[`VPR_KIND_BIT] ? desc_mem[widx] : base_mem[widx];
        if (!avs_address[`VPR_KIND_BIT]) begin
          rdata_next[15:12] = 4'h0;
        end
      end else begin
        unique case (avs_address)
          `VPR_CTRL_OFS: rdata_next[0] = map_en_reg;
          `VPR_STAT_OFS: rdata_next[3:0] = stat_reg;
          `VPR_IEN_OFS: rdata_next[3:0] = ien_reg;
          default: rdata_next = '0;
        endcase
      end
    end
  end

  // Control, status and enable; a new event beats a same-cycle clear
  always_comb begin
    map_en_next = map_en_reg;
    ien_next = ien_reg;
    clr_mask = '0;
    if (wr_go && avs_address == `VPR_CTRL_OFS) begin
      map_en_next = avs_writedata[0];
    end
    if (wr_go && avs_address == `VPR_IEN_OFS) begin
      ien_next = avs_writedata[3:0];
    end
    if (wr_go && avs_address == `VPR_ICLR_OFS) begin
      clr_mask = avs_writedata[3:0];
    end
    stat_next = (stat_reg & ~clr_mask) | (xlat_req.valid && map_en_reg ? ev : 4'h0);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      resp_reg <= 1'b0;
      rdata_reg <= '0;
      map_en_reg <= 1'b0;
      ien_reg <= `VPR_EV_RST;
      stat_reg <= `VPR_EV_RST;
    end else begin
      resp_reg <= resp_next;
      rdata_reg <= rdata_next;
      map_en_reg <= map_en_next;
      ien_reg <= ien_next;
      stat_reg <= stat_next;
    end
  end

  // Entry arrays; reserved base bits are dropped on write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < ENTRIES; i++) begin
        base_mem[i] <= `VPR_ENTRY_RST;
        desc_mem[i] <= `VPR_ENTRY_RST;
      end
    end else begin
      if (base_we) begin
        base_mem[widx] <= {4'h0, avs_writedata[11:0]};
      end
      if (desc_we) begin
        desc_mem[widx] <= avs_writedata[15:0];
      end
    end
  end

  assign avs_waitrequest = access && !resp_reg;
  assign avs_readdata = rdata_reg;
  assign irq = |(stat_reg & ien_reg);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_flat_io;
    xlat_req.valid && !map_en_reg && page == `VPR_IO_PAGE;
  endsequence

  sequence s_bus_req;
    access && avs_waitrequest;
  endsequence

  a_flat_io_ext: assert property (s_flat_io
      |=> xlat_rsp.done && xlat_rsp.paddr[17:16] == 2'h3)
    else $error("flat I/O page not extended");

  // Below the I/O page the flat address passes through unchanged
  a_flat_pass: assert property (xlat_req.valid && !map_en_reg && page != `VPR_IO_PAGE
      |=> xlat_rsp.done && xlat_rsp.paddr == {2'h0, $past(xlat_req.vaddr)})
    else $error("flat address altered");

  a_mode_abort: assert property (xlat_req.valid && map_en_reg && mode_bad
      |=> xlat_rsp.abort)
    else $error("illegal mode did not abort");

  a_key_none: assert property (xlat_req.valid && map_en_reg && key_bad
      |=> xlat_rsp.abort && !xlat_rsp.done)
    else $error("no-access page completed");

  a_ro_write: assert property (xlat_req.valid && map_en_reg && !mode_bad && ro_bad
      |=> xlat_rsp.abort && stat_reg != 4'h0)
    else $error("write to read-only page completed");

  a_len_limit: assert property (xlat_req.valid && map_en_reg && len_bad |=> !xlat_rsp.done)
    else $error("reference past page length completed");

  a_map_addr: assert property (xlat_req.valid && map_en_reg && !abort_c
      |=> xlat_rsp.done
      && xlat_rsp.paddr == {$past(base), 6'h00} + {5'h00, $past(xlat_req.vaddr[12:0])})
    else $error("mapped address wrong");

  a_abort_quiet: assert property (xlat_rsp.abort
      |-> !xlat_rsp.done && xlat_rsp.paddr == 18'h00000)
    else $error("aborted reference produced an address");

  a_sp_bank: assert property (sp_wr && xlat_req.mode == `VPR_MODE_PRIV
      |=> sp_reg[0] == $past(sp_wdata) && $stable(sp_reg[1]))
    else $error("stack pointer bank wrong");

  a_sp_user: assert property (sp_wr && xlat_req.mode == `VPR_MODE_UNPRIV
      |=> sp_reg[1] == $past(sp_wdata) && $stable(sp_reg[0]))
    else $error("unprivileged stack pointer wrong");

  // Status bits fall only through the clear register
  a_stat_sticky: assert property (!(wr_go && avs_address == `VPR_ICLR_OFS)
      |=> (stat_reg & $past(stat_reg)) == $past(stat_reg))
    else $error("status bit lost without a clear");

  a_bus_answer: assert property (s_bus_req |=> !avs_waitrequest)
    else $error("bus answer late");

endmodule : virtual_page_relocation

//--- rtl/vpr_regs.svh
// Offsets, field positions, reset values and timing counts of the page relocation block
// Overview of operation
// - Mapping off: addresses 160000-177777 get both upper physical bits forced to one.
// - Two banks of eight entries, each a 16-bit base and 16-bit descriptor pair.
// - Privileged mode translates through bank zero, unprivileged mode through bank one.
// - Mapping on: 16-bit address is virtual, combined with its entry into 18 bits.
// - Eight pages of up to 4K words, each relocated through its own entry.
// - Page length runs from one to 128 blocks of 32 words.
// - Page base sits on any 32-word boundary, counted in 32-word blocks.
// - Short pages allow access only inside their length; beyond it the reference aborts.
// - Several entries may point at one physical region, even with different keys.
// - Three protection levels per page: no access, read only, read/write.
// - Unprivileged mode refuses instructions that could halt or touch privileged space.
// - Two stack pointers, one per mode, chosen by the current mode.
// - Mapped space reaches 124K words; top 4K physical words are the I/O page.
// - Mode 00 selects privileged bank, 11 unprivileged; 01 and 10 abort everything while mapping is on.
// - Base register holds a 12-bit base field low; bits 15-12 are reserved.
// - Access keys 0 and 2 abort any reference; key 1 allows reads, aborts writes.
`ifndef VPR_REGS_SVH
`define VPR_REGS_SVH
`define VPR_ENTRY_TOP 8'h80
`define VPR_CTRL_OFS 8'h80
`define VPR_STAT_OFS 8'h84
`define VPR_IEN_OFS 8'h88
`define VPR_ICLR_OFS 8'h8c
`define VPR_BANK_BIT 6
`define VPR_KIND_BIT 5
`define VPR_BASE_W 12
`define VPR_BLK_SHIFT 6
`define VPR_KEY_LSB 1
`define VPR_LEN_LSB 8
`define VPR_KEY_RO 2'h1
`define VPR_KEY_RW 2'h3
`define VPR_MODE_PRIV 2'h0
`define VPR_MODE_UNPRIV 2'h3
`define VPR_IO_PAGE 3'h7
`define VPR_IO_EXT 2'h3
`define VPR_ENTRY_RST 16'h0000
`define VPR_EV_RST 4'h0
`define VPR_SP_RST 16'h0000
`define VPR_EV_MODE 0
`define VPR_EV_KEY 1
`define VPR_EV_RO 2
`define VPR_EV_LEN 3
`define VPR_XLAT_CYC 1
`endif

//--- rtl/vpr_pkg.sv
// Types shared by the page relocation block and its users
package vpr_pkg;
  // Address request from the processor core
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] mode;
    logic [15:0] vaddr;
  } xlat_req_t;

  // Registered answer toward the core and memory bus
  typedef struct packed {
    logic done;
    logic abort;
    logic io_page;
    logic [17:0] paddr;
  } xlat_rsp_t;
endpackage : vpr_pkg

//--- bench/vpr_core_model.sv
// Processor core side model presenting one address reference per clock
module vpr_core_model (
  input wire logic go,
  input wire logic wr,
  input wire logic [1:0] mode,
  input wire logic [15:0] vad,
  output vpr_pkg::xlat_req_t xlat_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle cycles show the inverted address so a stale one never looks live
  assign xlat_req = '{go, wr, mode, go ? vad : ~vad};
endmodule : vpr_core_model

//--- bench/tb.sv
// Self-checking bench for the page relocation block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [15:0] vad = 16'h0;
  vpr_pkg::xlat_req_t xlat_req;
  vpr_pkg::xlat_rsp_t xlat_rsp;
  vpr_pkg::xlat_rsp_t expq[$];
  logic priv_instr_ok;
  logic sp_wr = 1'b0;
  logic [15:0] sp_wdata = 16'h0;
  logic [15:0] sp_rdata;
  logic [15:0] mb [2][8];
  logic [15:0] md [2][8];
  logic [15:0] spm [2] = '{16'h0, 16'h0};
  logic [3:0] stat = 4'h0;
  logic en = 1'b0;
  logic [31:0] r;
  logic [31:0] q;
  int errors = 0;
  int cmp_count = 0;

  virtual_page_relocation u_virtual_page_relocation (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .xlat_req(xlat_req),
    .xlat_rsp(xlat_rsp), .priv_instr_ok(priv_instr_ok), .sp_wr(sp_wr),
    .sp_wdata(sp_wdata), .sp_rdata(sp_rdata));
  vpr_core_model u_vpr_core_model (
    .go(go), .wr(wr), .mode(mode), .vad(vad), .xlat_req(xlat_req));

  // Free running 125 MHz clock
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Checking and reference model
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // First failing check wins, as the status priority demands
  function automatic vpr_pkg::xlat_rsp_t expect_rsp(logic w, logic [1:0] m, logic [15:0] a);
    vpr_pkg::xlat_rsp_t e;
    logic [15:0] d;
    logic [3:0] ev;
    e = '0;
    ev = 4'h0;
    d = md[m == 2'h3][a[15:13]];
    if (!en) begin
      e.paddr = {(a[15:13] == 3'h7) ? 2'h3 : 2'h0, a};
    end else begin
      if (m == 2'h1 || m == 2'h2) ev = 4'h1;
      else if (d[2:1] != 2'h1 && d[2:1] != 2'h3) ev = 4'h2;
      else if (d[2:1] == 2'h1 && w) ev = 4'h4;
      else if (a[12:6] > d[14:8]) ev = 4'h8;
      e.paddr = {mb[m == 2'h3][a[15:13]][11:0], 6'h0} + 18'(a[12:0]);
    end
    stat = stat | ev;
    e.abort = (ev != 4'h0);
    e.done = !e.abort;
    if (e.abort) e.paddr = '0;
    e.io_page = e.done && (e.paddr[17:13] == 5'h1f);
    return e;
  endfunction : expect_rsp

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  // One reference per cycle; answer of the previous one is checked here
  task automatic step(input logic g, input logic w, input logic [1:0] m,
                      input logic [15:0] a, input logic s);
    @(posedge sys_clk);
    go <= g;
    wr <= w;
    mode <= m;
    vad <= a;
    sp_wr <= s;
    sp_wdata <= ~a;
    #1;
    chk(32'(xlat_rsp), 32'(expq.pop_front()));
    chk(32'(priv_instr_ok), 32'(m == 2'h0));
    chk(32'(sp_rdata), 32'(spm[m != 2'h0]));
    if (s) spm[m != 2'h0] = ~a;
    expq.push_back(g ? expect_rsp(w, m, a) : '0);
  endtask : step

  task automatic rsteps(input int n);
    repeat (n) begin
      r = $urandom;
      step(r[0], r[1], r[3:2], r[31:16], r[4]);
    end
    step(1'b0, 1'b0, 2'h0, 16'h0, 1'b0);
  endtask : rsteps

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  // Watchdog against a hung handshake
  initial begin
    #200000;
    errors++;
    close_out();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h6f02));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    expq.push_back('0);
    rsteps(60);
    // Page 0 full length read/write; entry 3 shared by both banks
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      mb[i / 8][i % 8] = (i == 11) ? mb[0][3] : r[15:0];
      md[i / 8][i % 8] = (i % 8 == 0) ? 16'h7f06 : r[31:16] & 16'h7f06;
      bus(1'b1, 8'((i / 8) * 64 + (i % 8) * 4), {16'h0, mb[i / 8][i % 8]});
      bus(1'b1, 8'((i / 8) * 64 + (i % 8) * 4 + 32), {16'h0, md[i / 8][i % 8]});
    end
    for (int i = 0; i < 16; i++) begin
      bus(1'b0, 8'((i / 8) * 64 + (i % 8) * 4), 32'h0);
      chk(q, {20'h0, mb[i / 8][i % 8][11:0]});
      bus(1'b0, 8'((i / 8) * 64 + (i % 8) * 4 + 32), 32'h0);
      chk(q, {16'h0, md[i / 8][i % 8]});
    end
    bus(1'b1, 8'hfc, 32'hffff);
    bus(1'b0, 8'hfc, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 8'h80, 32'h1);
    bus(1'b0, 8'h80, 32'h0);
    chk(q, 32'h1);
    en = 1'b1;
    rsteps(400);
    bus(1'b0, 8'h84, 32'h0);
    chk(q, {28'h0, stat});
    #1;
    chk(32'(irq), 32'h0);
    bus(1'b1, 8'h88, 32'hf);
    #1;
    chk(32'(irq), 32'(stat != 4'h0));
    bus(1'b0, 8'h88, 32'h0);
    chk(q, 32'hf);
    bus(1'b1, 8'h8c, {28'h0, stat});
    #1;
    chk(32'(irq), 32'h0);
    bus(1'b0, 8'h84, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 8'h8c, 32'h0);
    chk(q, 32'h0);
    close_out();
  end
endmodule : tb
